// *** pwm_channel_out.sv ***
// compare detector and output pin state for one channel
`timescale 1ns/100ps
module pwm_channel_out
   import timer_pwm_pkg::*;
#(
   parameter int WIDTH = CNT_W
) (
   // clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rstn_in,
   // counter events
   input  wire logic             tick_in,
   input  wire logic             wrap_evt_in,
   input  wire logic [WIDTH-1:0] count_in,
   // channel setup
   input  wire logic             enable_in,
   input  wire logic [WIDTH-1:0] value_in,
   input  wire logic [1:0]       action_in,
   input  wire logic             tov_in,
   input  wire logic             full_in,
   // results
   output logic                  match_out,
   output logic                  pin_out
);
   logic pin_reg;
   logic pin_next;

   generate
      if (WIDTH < 2) begin : g_bad
         $error("pwm_channel_out: WIDTH must be at least 2");
      end
   endgenerate

   // ==================================================
   // compare only when the counter itself lands on the value
   assign match_out = enable_in && tick_in &&
                      (count_in == value_in);

   always_comb begin
      pin_next = pin_reg;
      if (full_in && !tov_in) begin
         pin_next = (action_in != ACT_SET);
      end else begin
         if (wrap_evt_in && tov_in) begin
            pin_next = ~pin_reg;
         end
         // after a wrap toggle the compare acts on the toggled level
         if (match_out) begin
            unique case (action_in)
               ACT_TOGGLE: pin_next = ~pin_next;
               ACT_CLEAR:  pin_next = 1'b0;
               ACT_SET:    pin_next = 1'b1;
               ACT_NONE:   pin_next = pin_next;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_reg <= 1'b0;
      end else if (enable_in) begin
         pin_reg <= pin_next;
      end
   end

   assign pin_out = pin_reg;
endmodule

// *** timer_pwm_channels.sv ***
// four-channel pwm timer with apb registers
`timescale 1ns/100ps
module timer_pwm_channels
   import timer_pwm_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys_in,
   input  wire logic              rstn_in,
   // apb slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [7:0]        paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // low power modes
   input  wire logic              wait_mode_in,
   input  wire logic              stop_mode_in,
   // channel pins
   output logic      [NCH-1:0]    ch_pin_out,
   output logic      [NCH-1:0]    ch_pin_oe_out,
   // interrupt requests
   output logic                   overflow_irq_out,
   output logic      [NCH-1:0]    channel_irq_out
);
   // ==================================================
   // state
   logic                 counter_halt_reg;
   logic                 overflow_flag_reg;
   logic                 overflow_irq_en_reg;
   logic                 ovf_armed_reg;
   logic [2:0]           presc_sel_reg;
   logic [PRE_W-1:0]     presc_cnt_reg;
   logic [CNT_W-1:0]     count_reg;
   logic [CNT_W-1:0]     wrap_limit_reg;
   logic [1:0]           mode_reg     [NCH];
   logic [1:0]           action_reg   [NCH];
   logic [NCH-1:0]       tov_reg;
   logic [NCH-1:0]       full_duty_reg;
   logic [NCH-1:0]       irq_en_reg;
   logic [NCH-1:0]       channel_flag_reg;
   logic [NCH-1:0]       ch_armed_reg;
   logic [CNT_W-1:0]     value_reg    [NCH];
   logic [1:0]           pair_sel_reg;
   logic [1:0]           pair_last_reg;
   logic [31:0]          prdata_reg;

   // ==================================================
   // bus decode
   logic                 access;
   logic                 wr;
   logic                 rd;
   logic                 ch_hit;
   logic [1:0]           ch_idx;
   logic                 ch_val_sel;
   logic                 mapped;
   logic                 wr_ctl;
   logic                 wr_wrap;
   logic [NCH-1:0]       wr_ch_ctl;
   logic [NCH-1:0]       wr_ch_val;
   logic                 rd_ctl;
   logic [NCH-1:0]       rd_ch_ctl;
   logic [31:0]          rd_mux;

   assign ch_hit     = (paddr_in[7:5] == CH_REGION) &&
                       (paddr_in[1:0] == 2'b00);
   assign ch_idx     = paddr_in[4:3];
   assign ch_val_sel = paddr_in[2];
   assign mapped     = ch_hit || (paddr_in == OFS_TIMER_CTL) ||
                       (paddr_in == OFS_COUNT) ||
                       (paddr_in == OFS_WRAP);
   // registers are locked out while the core waits
   assign access     = psel_in && penable_in && mapped &&
                       !wait_mode_in;
   assign wr         = access && pwrite_in;
   assign rd         = access && !pwrite_in;
   assign wr_ctl     = wr && (paddr_in == OFS_TIMER_CTL);
   assign wr_wrap    = wr && (paddr_in == OFS_WRAP);
   assign rd_ctl     = rd && (paddr_in == OFS_TIMER_CTL);

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         wr_ch_ctl[i] = wr && ch_hit && !ch_val_sel &&
                        (ch_idx == 2'(i));
         wr_ch_val[i] = wr && ch_hit && ch_val_sel &&
                        (ch_idx == 2'(i));
         rd_ch_ctl[i] = rd && ch_hit && !ch_val_sel &&
                        (ch_idx == 2'(i));
      end
   end

   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in &&
                        (!mapped || wait_mode_in);
   assign prdata_out  = prdata_reg;

   // ==================================================
   // read mux, sampled in the setup cycle
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (wait_mode_in) begin
         rd_mux = 32'h0000_0000;
      end else if (paddr_in == OFS_TIMER_CTL) begin
         rd_mux[TC_FLAG]  = overflow_flag_reg;
         rd_mux[TC_IRQEN] = overflow_irq_en_reg;
         rd_mux[TC_HALT]  = counter_halt_reg;
         rd_mux[TC_PS_LO +: 3] = presc_sel_reg; // clear bit reads 0
      end else if (paddr_in == OFS_COUNT) begin
         rd_mux[CNT_W-1:0] = count_reg;
      end else if (paddr_in == OFS_WRAP) begin
         rd_mux[CNT_W-1:0] = wrap_limit_reg;
      end else if (ch_hit && ch_val_sel) begin
         rd_mux[CNT_W-1:0] = value_reg[ch_idx];
      end else if (ch_hit) begin
         rd_mux[CC_FLAG]  = channel_flag_reg[ch_idx];
         rd_mux[CC_IRQEN] = irq_en_reg[ch_idx];
         rd_mux[CC_MODEH +: 1] = mode_reg[ch_idx][1];
         rd_mux[CC_MODEL] = mode_reg[ch_idx][0];
         rd_mux[CC_ACT_L +: 2] = action_reg[ch_idx];
         rd_mux[CC_TOV]   = tov_reg[ch_idx];
         rd_mux[CC_FULL]  = full_duty_reg[ch_idx];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prdata_reg <= 32'h0000_0000;
      end else if (psel_in && !penable_in && !pwrite_in) begin
         prdata_reg <= rd_mux;
      end
   end

   // ==================================================
   // prescaler and counter
   logic                 running;
   logic [PRE_W-1:0]     presc_mask;
   logic                 tick;
   logic                 wrap_evt;
   logic                 clear_req;

   assign running    = !counter_halt_reg && !stop_mode_in;
   assign presc_mask = PRE_W'((7'd1 << presc_sel_reg) - 7'd1);
   // external clock source is not served: the counter idles
   assign tick       = running && (presc_sel_reg != PS_EXT) &&
                       ((presc_cnt_reg & presc_mask) == presc_mask);
   assign wrap_evt   = tick && (count_reg == wrap_limit_reg);
   assign clear_req  = wr_ctl && pwdata_in[TC_CLEAR];

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         presc_cnt_reg <= '0;
      end else if (clear_req) begin
         presc_cnt_reg <= '0;
      end else if (running) begin
         presc_cnt_reg <= presc_cnt_reg + PRE_W'(1);
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_reg <= '0;
      end else if (clear_req) begin
         count_reg <= '0;
      end else if (wrap_evt) begin
         count_reg <= '0;
      end else if (tick) begin
         count_reg <= count_reg + CNT_W'(1);
      end
   end

   // ==================================================
   // timer control register and overflow flag
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         counter_halt_reg    <= HALT_RST;
         overflow_irq_en_reg <= 1'b0;
         presc_sel_reg       <= 3'h0;
         wrap_limit_reg      <= WRAP_RST;
      end else begin
         if (wr_ctl) begin
            counter_halt_reg    <= pwdata_in[TC_HALT];
            overflow_irq_en_reg <= pwdata_in[TC_IRQEN];
            presc_sel_reg       <= pwdata_in[TC_PS_LO +: 3];
         end
         if (wr_wrap) begin
            wrap_limit_reg <= pwdata_in[CNT_W-1:0];
         end
      end
   end

   // flag clears by a read while set, then a write of zero;
   // a wrap in between disarms the clear
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         overflow_flag_reg <= 1'b0;
         ovf_armed_reg     <= 1'b0;
      end else if (wrap_evt) begin
         overflow_flag_reg <= 1'b1;
         ovf_armed_reg     <= 1'b0;
      end else if (wr_ctl && !pwdata_in[TC_FLAG] && ovf_armed_reg) begin
         overflow_flag_reg <= 1'b0;
         ovf_armed_reg     <= 1'b0;
      end else if (rd_ctl && overflow_flag_reg) begin
         ovf_armed_reg <= 1'b1;
      end
   end

   // ==================================================
   // channel control registers and values
   logic [1:0] link;

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < NCH; i++) begin
            mode_reg[i]   <= MODE_CAPTURE;
            action_reg[i] <= ACT_NONE;
            value_reg[i]  <= '0;
         end
         tov_reg       <= '0;
         full_duty_reg <= '0;
         irq_en_reg    <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_ch_ctl[i]) begin
               // odd channels have no link bit
               mode_reg[i][1]   <= (i % 2 == 1) ? 1'b0 :
                                   pwdata_in[CC_MODEH];
               mode_reg[i][0]   <= pwdata_in[CC_MODEL];
               action_reg[i]    <= pwdata_in[CC_ACT_L +: 2];
               tov_reg[i]       <= pwdata_in[CC_TOV];
               full_duty_reg[i] <= pwdata_in[CC_FULL];
               irq_en_reg[i]    <= pwdata_in[CC_IRQEN];
            end
            if (wr_ch_val[i]) begin
               value_reg[i] <= pwdata_in[CNT_W-1:0];
            end
         end
      end
   end

   // ==================================================
   // linked pairs: selection swaps only at a wrap
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pair_sel_reg  <= 2'b00;
         pair_last_reg <= 2'b00;
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (!link[p]) begin
               // even register leads once a link is made
               pair_sel_reg[p]  <= 1'b0;
               pair_last_reg[p] <= 1'b0;
            end else begin
               if (wr_ch_val[2*p+1]) begin
                  pair_last_reg[p] <= 1'b1;
               end else if (wr_ch_val[2*p]) begin
                  pair_last_reg[p] <= 1'b0;
               end
               if (wrap_evt) begin
                  pair_sel_reg[p] <= pair_last_reg[p];
               end
            end
         end
      end
   end

   // ==================================================
   // compare units
   logic [NCH-1:0]   ch_enable;
   logic [NCH-1:0]   ch_match;
   logic [NCH-1:0]   ch_pin;
   logic [CNT_W-1:0] active_value [NCH];

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         // link bit takes precedence over the low mode bit
         link[p] = mode_reg[2*p][1];
         ch_enable[2*p]   = link[p] ||
                            (mode_reg[2*p] == MODE_UNBUF);
         // odd channel released to general i/o while linked
         ch_enable[2*p+1] = !link[p] &&
                            (mode_reg[2*p+1] == MODE_UNBUF);
         active_value[2*p]   = (link[p] && pair_sel_reg[p]) ?
                               value_reg[2*p+1] :
                               value_reg[2*p];
         active_value[2*p+1] = value_reg[2*p+1];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         pwm_channel_out #(
            .WIDTH (CNT_W)
         ) u_out (
            .clk_sys_in  (clk_sys_in),
            .rstn_in     (rstn_in),
            .tick_in     (tick),
            .wrap_evt_in (wrap_evt),
            .count_in    (count_reg),
            .enable_in   (ch_enable[g]),
            .value_in    (active_value[g]),
            .action_in   (action_reg[g]),
            .tov_in      (tov_reg[g]),
            .full_in     (full_duty_reg[g]),
            .match_out   (ch_match[g]),
            .pin_out     (ch_pin[g])
         );
      end
   endgenerate

   assign ch_pin_out    = ch_pin;
   assign ch_pin_oe_out = ch_enable;

   // ==================================================
   // channel flags: two-step clear, a new compare wins
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         channel_flag_reg <= '0;
         ch_armed_reg     <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (ch_match[i]) begin
               channel_flag_reg[i] <= 1'b1;
               ch_armed_reg[i]     <= 1'b0;
            end else if (wr_ch_ctl[i] && !pwdata_in[CC_FLAG] &&
                         ch_armed_reg[i]) begin
               channel_flag_reg[i] <= 1'b0;
               ch_armed_reg[i]     <= 1'b0;
            end else if (rd_ch_ctl[i] && channel_flag_reg[i]) begin
               ch_armed_reg[i] <= 1'b1;
            end
         end
      end
   end

   // ==================================================
   // interrupt requests, live in wait mode to wake the core
   assign overflow_irq_out = overflow_flag_reg &&
                             overflow_irq_en_reg;
   assign channel_irq_out  = channel_flag_reg &
                             irq_en_reg;
endmodule

// *** timer_pwm_channels_assertions.sv ***
// port-level assertions for the pwm timer
`timescale 1ns/100ps
module timer_pwm_channels_assertions
   import timer_pwm_pkg::*;
(
   // clock and reset
   input wire logic           clk_sys_in,
   input wire logic           rstn_in,
   // apb
   input wire logic           psel_in,
   input wire logic           penable_in,
   input wire logic           pwrite_in,
   input wire logic [7:0]     paddr_in,
   input wire logic [31:0]    pwdata_in,
   input wire logic [31:0]    prdata_out,
   input wire logic           pready_out,
   input wire logic           pslverr_out,
   // low power modes
   input wire logic           wait_mode_in,
   input wire logic           stop_mode_in,
   // pins and interrupts
   input wire logic [NCH-1:0] ch_pin_out,
   input wire logic [NCH-1:0] ch_pin_oe_out,
   input wire logic           overflow_irq_out,
   input wire logic [NCH-1:0] channel_irq_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   logic acc;
   logic wr;
   assign acc = psel_in && penable_in;
   assign wr  = acc && pwrite_in;
   // ==========================================
   // bus refusal in wait mode
   a_wait_refused: assert property (
      acc && wait_mode_in |-> pslverr_out)
      else $error("access in wait mode not refused");
   a_wait_read_zero: assert property (
      psel_in && !penable_in && !pwrite_in && wait_mode_in ##1 acc
      |-> prdata_out == '0)
      else $error("read in wait mode returned data");
   a_mapped_ok: assert property (
      acc && !wait_mode_in && paddr_in == OFS_WRAP |-> !pslverr_out)
      else $error("mapped access refused outside wait");
   a_err_in_access: assert property (!acc |-> !pslverr_out)
      else $error("error flag outside access phase");
   // ==========================================
   // stop mode and interrupt levels
   a_stop_frozen: assert property (
      $past(stop_mode_in) && !$past(wr) |-> $stable(ch_pin_out)
      && $stable(channel_irq_out) && $stable(overflow_irq_out))
      else $error("activity while stopped");
   a_ovf_irq_held: assert property (
      overflow_irq_out && !(wr && paddr_in == OFS_TIMER_CTL)
      |=> overflow_irq_out)
      else $error("overflow request dropped without write");
   a_ch_irq_held: assert property (
      !(wr && paddr_in[5]) |=> ($past(channel_irq_out) & ~channel_irq_out) == '0)
      else $error("channel request dropped without write");
   a_oe_static: assert property (!wr |=> $stable(ch_pin_oe_out))
      else $error("pin enable changed without write");
   c_ovf: cover property ($rose(overflow_irq_out));
   c_ch0: cover property ($rose(channel_irq_out[0]));
   c_wait: cover property (acc && wait_mode_in && pslverr_out);
endmodule

// *** timer_pwm_channels_tb.sv ***
// self-checking bench for the pwm timer
`timescale 1ns/100ps
module timer_pwm_channels_tb
   import timer_pwm_pkg::*;
;
   logic           clk_sys_in, rstn_in, psel_in, penable_in;
   logic           pwrite_in, wait_mode_in, stop_mode_in, err;
   logic [7:0]     paddr_in;
   logic [31:0]    pwdata_in, prdata_out, rd, hi, keep;
   logic           pready_out, pslverr_out, overflow_irq_out;
   logic [NCH-1:0] ch_pin_out, ch_pin_oe_out, channel_irq_out;
   int             mismatches, check_count;
   timer_pwm_channels u_timer_pwm_channels (
      .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in),
      .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .wait_mode_in(wait_mode_in),
      .stop_mode_in(stop_mode_in), .ch_pin_out(ch_pin_out),
      .ch_pin_oe_out(ch_pin_oe_out), .overflow_irq_out(overflow_irq_out),
      .channel_irq_out(channel_irq_out));
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // ==========================================
   // access and compare tasks
   task automatic check(input logic [31:0] seen, exp, input string what);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_sys_in);
      end while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp, what);
   endtask
   // counts high samples over four periods of eight cycles
   task automatic duty(input int ch, input logic [31:0] exp,
                       input string what);
      repeat (10) @(posedge clk_sys_in);
      hi = '0;
      repeat (32) begin
         @(negedge clk_sys_in);
         hi = hi + {31'b0, ch_pin_out[ch]};
      end
      check(hi, exp, what);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_sys_in);
      mismatches++;
      close_out;
   end
   // ==========================================
   // test sequence
   initial begin
      {psel_in, penable_in, pwrite_in, wait_mode_in, stop_mode_in} = '0;
      paddr_in = '0;
      pwdata_in = '0;
      mismatches = 0;
      check_count = 0;
      rstn_in = 1'b0;
      repeat (3) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      rdchk(OFS_TIMER_CTL, 32'h0000_0020, "ctl reset");
      rdchk(OFS_WRAP, 32'h0000_FFFF, "wrap reset");
      rdchk(8'h10, 32'h0000_0000, "unmapped read");
      check({31'b0, err}, 32'h0000_0001, "unmapped err");
      wr(OFS_TIMER_CTL, 32'h0000_0030);
      rdchk(OFS_COUNT, 32'h0000_0000, "count cleared");
      rdchk(OFS_TIMER_CTL, 32'h0000_0020, "clear self");
      wr(OFS_WRAP, 32'h0000_0007);
      wr(8'h24, 32'h0000_0003);
      wr(8'h20, 32'h0000_005A);
      wr(OFS_TIMER_CTL, 32'h0000_0040);
      duty(0, 32'h0000_0010, "unbuffered duty");
      check({31'b0, overflow_irq_out}, 32'h0000_0001, "ovf irq");
      check({28'b0, channel_irq_out}, 32'h0000_0001, "ch irq");
      check({28'b0, ch_pin_oe_out}, 32'h0000_0001, "oe by mode");
      rdchk(OFS_TIMER_CTL, 32'h0000_00C0, "ovf flag");
      // halt first so no wrap can disarm the two-step clear
      wr(OFS_TIMER_CTL, 32'h0000_00E0);
      rdchk(OFS_TIMER_CTL, 32'h0000_00E0, "halted flag");
      wr(OFS_TIMER_CTL, 32'h0000_0040);
      @(negedge clk_sys_in);
      check({31'b0, overflow_irq_out}, 32'h0000_0000, "irq off");
      @(posedge ch_pin_out[0]);
      wr(8'h24, 32'h0000_0005);
      duty(0, 32'h0000_0018, "new width");
      check({31'b0, overflow_irq_out}, 32'h0000_0001, "ovf again");
      @(negedge ch_pin_out[0]);
      wr(8'h24, 32'h0000_0002);
      duty(0, 32'h0000_000C, "shorter width");
      wr(8'h20, 32'h0000_0058);
      duty(0, 32'h0000_0000, "zero duty");
      wr(8'h20, 32'h0000_0059);
      duty(0, 32'h0000_0020, "full duty");
      wr(8'h20, 32'h0000_005E);
      duty(0, 32'h0000_0014, "set action");
      $display("test unbuffered done");
      for (int p = 0; p < 4; p += 2) begin
         wr(8'(8'h28 + 8 * p), 32'h0000_001A);
         duty(p + 1, 32'h0000_0004, "odd unlinked");
         wr(8'(8'h24 + 8 * p), 32'h0000_0003);
         wr(8'(8'h20 + 8 * p), 32'h0000_003A);
         @(negedge clk_sys_in);
         check({31'b0, ch_pin_oe_out[p+1]}, 32'h0000_0000, "odd off");
         duty(p, 32'h0000_0010, "even first");
         wr(8'(8'h2C + 8 * p), 32'h0000_0005);
         duty(p, 32'h0000_0018, "odd takes over");
         wr(8'(8'h24 + 8 * p), 32'h0000_0001);
         duty(p, 32'h0000_0008, "even again");
      end
      $display("test buffered done");
      @(posedge clk_sys_in);
      wait_mode_in <= 1'b1;
      wr(OFS_WRAP, 32'h0000_0003);
      check({31'b0, err}, 32'h0000_0001, "wait write err");
      rdchk(OFS_WRAP, 32'h0000_0000, "wait read");
      duty(2, 32'h0000_0008, "runs in wait");
      check({31'b0, overflow_irq_out}, 32'h0000_0001, "wake req");
      @(posedge clk_sys_in);
      wait_mode_in <= 1'b0;
      rdchk(OFS_WRAP, 32'h0000_0007, "wrap kept");
      $display("test wait done");
      @(posedge clk_sys_in);
      stop_mode_in <= 1'b1;
      apb(1'b0, OFS_COUNT, 32'h0000_0000);
      keep = rd;
      repeat (20) @(posedge clk_sys_in);
      rdchk(OFS_COUNT, keep, "count frozen");
      @(posedge clk_sys_in);
      stop_mode_in <= 1'b0;
      duty(2, 32'h0000_0008, "resumes");
      $display("test stop done");
      close_out;
   end
endmodule
bind timer_pwm_channels timer_pwm_channels_assertions u_chk (
   .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out),
   .wait_mode_in(wait_mode_in), .stop_mode_in(stop_mode_in),
   .ch_pin_out(ch_pin_out), .ch_pin_oe_out(ch_pin_oe_out),
   .overflow_irq_out(overflow_irq_out),
   .channel_irq_out(channel_irq_out));

// *** timer_pwm_pkg.sv ***
// constants shared by the four-channel pwm timer
package timer_pwm_pkg;
   // ==================================================
   // widths
   localparam int CNT_W  = 16;
   localparam int NCH    = 4;
   localparam int PRE_W  = 6;
   // ==================================================
   // register byte addresses
   localparam logic [7:0] OFS_TIMER_CTL = 8'h00;
   localparam logic [7:0] OFS_COUNT     = 8'h04;
   localparam logic [7:0] OFS_WRAP      = 8'h08;
   localparam logic [2:0] CH_REGION     = 3'h1;
   // channel n: control at 0x20 + 8n, value at 0x24 + 8n
   // ==================================================
   // timer_ctl_status fields
   localparam int TC_FLAG  = 7;
   localparam int TC_IRQEN = 6;
   localparam int TC_HALT  = 5;
   localparam int TC_CLEAR = 4;
   localparam int TC_PS_LO = 0;
   // ==================================================
   // channel_ctl_status fields
   localparam int CC_FLAG  = 7;
   localparam int CC_IRQEN = 6;
   localparam int CC_MODEH = 5;
   localparam int CC_MODEL = 4;
   localparam int CC_ACT_H = 3;
   localparam int CC_ACT_L = 2;
   localparam int CC_TOV   = 1;
   localparam int CC_FULL  = 0;
   // ==================================================
   // reset values and the external clock select code
   localparam logic [CNT_W-1:0] WRAP_RST = 16'hFFFF;
   localparam logic             HALT_RST = 1'b1;
   localparam logic [2:0]       PS_EXT   = 3'h7;
   // ==================================================
   // channel mode select and compare action encodings
   typedef enum logic [1:0] {
      MODE_CAPTURE = 2'b00,
      MODE_UNBUF   = 2'b01,
      MODE_BUF     = 2'b10
   } channel_mode_t;
   typedef enum logic [1:0] {
      ACT_NONE   = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_CLEAR  = 2'b10,
      ACT_SET    = 2'b11
   } compare_action_t;
endpackage
